// *** shared/slm_regs.svh ***
// Constants of the single instruction loop controller.
// Assumes 16-bit instruction words and a 16-bit low counter word.
`ifndef SLM_REGS_SVH
`define SLM_REGS_SVH
`define SLM_COUNT_EXPIRED 16'hffff
`define SLM_LOOP_DISP     16'hfffc
`define SLM_MODE_IND      3'h2
`define SLM_MODE_POSTINC  3'h3
`define SLM_MODE_PREDEC   3'h4
`define SLM_MODE_DREG     3'h0
`define SLM_MODE_AREG     3'h1
`define SLM_SIZE_BAD      2'h3
`define SLM_ST_IDLE       4'h1
`define SLM_ST_ARMED      4'h2
`define SLM_ST_LOOP       4'h4
`define SLM_ST_SUSPEND    4'h8
`endif

// *** shared/slm_pkg.sv ***
// Types of the single instruction loop controller.
// Assumes slm_regs.svh is on the include path.
`include "slm_regs.svh"
package slm_pkg;
   // Loop controller states, one-hot
   typedef enum logic [3:0] {
      SLM_IDLE    = `SLM_ST_IDLE,
      SLM_ARMED   = `SLM_ST_ARMED,
      SLM_LOOP    = `SLM_ST_LOOP,
      SLM_SUSPEND = `SLM_ST_SUSPEND
   } slm_state_type;
endpackage

// *** hdl/slm_loop_ctrl.sv ***
// Single instruction loop controller of the processor front end.
// Assumes the sequencer reports every fetched word, every completed
// instruction and every decrement_and_branch outcome as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "slm_regs.svh"

// Function
// RULE1: Decrement counter low word; minus one falls through
// RULE2: Condition true discards count, continues sequentially; a count of zero is still decremented and written back
// RULE3: Otherwise add displacement to program counter
// RULE4: Decode register plus two-word queue hold loop
// RULE5: No opcode fetches while loop mode runs
// RULE6: Enter on looping branch, displacement minus four
// RULE7: Enter at second fetch of eligible instruction
// RULE8: Leave on exhausted count or true condition
// RULE9: Interrupts only after branch; taking one exits
// RULE10: Trace after every instruction; never loop
// RULE11: Reset aborts processing and clears loop state
// RULE12: Bus error suspends; resume without refetching loop
// RULE13: Only one-word indirect, postincrement, predecrement forms
// RULE14: Moves between memory modes, register to postincrement
// RULE15: Memory into data register arithmetic and logic
// RULE16: Address register add, compare, subtract from memory
// RULE17: Data register into memory arithmetic and logic
// RULE18: Single operand memory operations; decimal negate byte
// RULE19: Word memory shifts and rotates by one
// RULE20: Extended ops predecrement; memory compare postincrement
module slm_loop_ctrl #(
   parameter int PC_W = 32                      // Program counter width
) (
   input  wire logic              clk,          // Processor clock
   input  wire logic              rst_n,        // Synchronous reset, active low
   input  wire logic              trace_en,     // Trace enable bit of status
   input  wire logic              irq_pending,  // An interrupt is pending
   input  wire logic              bus_error,    // Bus error pulse
   input  wire logic              rte_resume,   // return_from_exception resumes looped op
   input  wire logic              fetch_valid,  // Opcode word fetched, pulse
   input  wire logic [15:0]       fetch_word,   // Fetched opcode word
   input  wire logic              instr_exec,   // Non-branch instruction completed, pulse
   input  wire logic [15:0]       instr_word,   // Its opcode word
   input  wire logic              dbr_exec,     // decrement_and_branch executes, pulse
   input  wire logic [15:0]       dbr_count,    // Low word of counter register
   input  wire logic              dbr_cond_true,// Branch condition against codes
   input  wire logic [15:0]       dbr_disp,     // Branch displacement
   input  wire logic [PC_W-1:0]   dbr_pc,       // Base program counter for the branch
   output logic                   loop_active_r,   // Loop mode running
   output logic                   fetch_inhibit_r, // Opcode fetches suppressed
   output logic                   count_we_r,      // Write decremented count back
   output logic [15:0]            count_wdata_r,   // Decremented count
   output logic                   branch_r,        // Branch to target_pc_r
   output logic [PC_W-1:0]        target_pc_r,     // Branch target
   output logic                   seq_r,           // Proceed sequentially
   output logic                   irq_take_r,      // Take interrupt now
   output logic                   trace_req_r,     // Raise trace exception
   output logic [15:0]            decode_word_r,   // Decode register
   output logic [15:0]            queue0_r,        // Prefetch queue, older word
   output logic [15:0]            queue1_r         // Prefetch queue, newer word
);

   // Data and address register direct modes are rejected here on purpose
   // True for the three address register indirect modes
   function automatic logic ind_mode(input logic [2:0] m);
      ind_mode = (m == `SLM_MODE_IND) || (m == `SLM_MODE_POSTINC) ||
                 (m == `SLM_MODE_PREDEC);
   endfunction

   // Opcode fields used by the eligibility decode:
   //   [15:12] operation group, [11:9] destination register,
   //   [8:6] operation mode or destination mode, [5:3] source mode,
   //   [2:0] source register.
   // Only one-word forms are decoded; a mode that would pull an
   // extension word (displacement, index, absolute, immediate) never
   // qualifies, because the queue has no room to hold it.
   // The decode is deliberately permissive about register numbers:
   // any register may be named, only the modes and the size matter.
   // Each arm below except the moves arm may only set ok; the moves arm assigns ok first, so the arms can
   // overlap without one hiding another.
   // Loop eligibility of a one-word opcode
   function automatic logic loop_ok(input logic [15:0] op);
      logic       src_ind;
      logic       dst_ind;
      logic [3:0] grp;
      logic [2:0] opm;
      logic       ok;
      src_ind = ind_mode(op[5:3]);
      dst_ind = ind_mode(op[8:6]);
      grp     = op[15:12];
      opm     = op[8:6];
      ok      = 1'b0;
      // Moves, all three sizes
      if (op[15:14] == 2'h0 && op[13:12] != 2'h0) begin
         ok = (src_ind && dst_ind) ||                                       // RULE14
              ((op[5:3] == `SLM_MODE_DREG || op[5:3] == `SLM_MODE_AREG) &&
               op[8:6] == `SLM_MODE_POSTINC);                                // RULE14
      end
      // Memory into data register
      if ((grp == 4'hd || grp == 4'hc || grp == 4'hb || grp == 4'h8 || grp == 4'h9) &&
          opm[2] == 1'b0 && opm[1:0] != 2'h3 && src_ind) begin
         ok = 1'b1;                                                          // RULE15
      end
      // Memory into address register
      if ((grp == 4'hd || grp == 4'hb || grp == 4'h9) && opm[1:0] == 2'h3 && src_ind) begin
         ok = 1'b1;                                                          // RULE16
      end
      // Data register into memory; compare excluded, exclusive_or included
      if ((grp == 4'hd || grp == 4'hc || grp == 4'hb || grp == 4'h8 || grp == 4'h9) &&
          opm[2] == 1'b1 && opm[1:0] != 2'h3 && src_ind) begin
         ok = 1'b1;                                                          // RULE17
      end
      // Decimal add/subtract extended, byte, predecrement pair
      if ((grp == 4'hc || grp == 4'h8) && op[8:3] == 6'h21) begin
         ok = 1'b1;                                                          // RULE20
      end
      // Add/subtract with extend, predecrement pair
      if ((grp == 4'hd || grp == 4'h9) && op[8] && op[7:6] != `SLM_SIZE_BAD &&
          op[5:3] == `SLM_MODE_AREG) begin
         ok = 1'b1;                                                          // RULE20
      end
      // Memory compare, postincrement pair
      if (grp == 4'hb && op[8] && op[7:6] != `SLM_SIZE_BAD && op[5:3] == `SLM_MODE_AREG) begin
         ok = 1'b1;                                                          // RULE20
      end
      // Clear, negate, negate with extend, complement, test
      if ((op[15:8] == 8'h40 || op[15:8] == 8'h42 || op[15:8] == 8'h44 ||
           op[15:8] == 8'h46 || op[15:8] == 8'h4a) && op[7:6] != `SLM_SIZE_BAD && src_ind) begin
         ok = 1'b1;                                                          // RULE18
      end
      // Decimal negate, byte only
      if (op[15:6] == 10'h120 && src_ind) begin
         ok = 1'b1;                                                          // RULE18
      end
      // Word memory shift or rotate by one
      if (op[15:11] == 5'h1c && op[7:6] == 2'h3 && src_ind) begin
         ok = 1'b1;                                                          // RULE19
      end
      loop_ok = ok;                                                          // RULE13
   endfunction

   // Controller state and the registered copies of every output.
   // Every output is a flip-flop so the sequencer sees clean levels
   // and pulses one cycle after the cause, never a combinational path
   // from its own strobes back into itself.
   slm_pkg::slm_state_type state_r;             // Loop controller state
   slm_pkg::slm_state_type state_nxt;
   logic [15:0]            last_op_r;           // Last non-branch opcode completed
   logic [15:0]            last_op_nxt;
   logic                   loop_active_nxt;
   logic                   fetch_inhibit_nxt;
   logic                   count_we_nxt;
   logic [15:0]            count_wdata_nxt;
   logic                   branch_nxt;
   logic [PC_W-1:0]        target_pc_nxt;
   logic                   seq_nxt;
   logic                   irq_take_nxt;
   logic                   trace_req_nxt;
   logic [15:0]            decode_word_nxt;
   logic [15:0]            queue0_nxt;
   logic [15:0]            queue1_nxt;
   logic [15:0]            dec_count;           // Counter after decrement
   logic                   expired;             // Count reached minus one
   logic                   loops;               // Branch goes back

   // The decrement is done on the low word only; the upper word of the
   // counter register is never touched, so a long count wraps at 16 bits.
   // expired feeds the outcome logic, and loops, built from it, feeds the entry test,
   // so the two always agree on whether the branch goes back.
   // Branch outcome, shared by all states
   always_comb begin
      dec_count = dbr_count - 16'h0001;                                     // RULE1
      expired   = (dec_count == `SLM_COUNT_EXPIRED);                        // RULE1
      loops     = !expired && !dbr_cond_true;                               // RULE3
   end

   // One process decides everything the controller does in a cycle:
   //   - the pulse outputs default to zero and rise only on their cause
   //   - the held values (count, target, queue) keep their last contents
   //   - the state machine walks idle, armed, loop and suspend
   // Idle to armed needs a looping backward branch by four bytes over an
   // eligible word; armed to loop needs the second fetch of that word.
   // Trace or a pending interrupt at the branch keeps the machine idle,
   // since trace would break the loop again at once and an interrupt on the very next branch.
   // Limitation: the looped word is matched by value, not by address.
   // A different word with the same encoding would also confirm entry.
   // Next state and outputs; the queue freezes once the loop is captured
   always_comb begin
      state_nxt         = state_r;
      last_op_nxt       = instr_exec ? instr_word : last_op_r;
      count_we_nxt      = 1'b0;
      count_wdata_nxt   = count_wdata_r;
      branch_nxt        = 1'b0;
      target_pc_nxt     = target_pc_r;
      seq_nxt           = 1'b0;
      decode_word_nxt   = decode_word_r;
      queue0_nxt        = queue0_r;
      queue1_nxt        = queue1_r;
      // Trace after each instruction, looped one included
      trace_req_nxt     = trace_en && (instr_exec || dbr_exec);              // RULE10
      // In loop mode interrupts wait for the branch
      irq_take_nxt      = irq_pending &&
                          (dbr_exec || (instr_exec && state_r != slm_pkg::SLM_LOOP)); // RULE9
      // Word shifting stops once the loop is held, so no refetch is needed
      if (fetch_valid && state_r != slm_pkg::SLM_LOOP && state_r != slm_pkg::SLM_SUSPEND) begin
         decode_word_nxt = queue0_r;                                         // RULE4
         queue0_nxt      = queue1_r;                                         // RULE4
         queue1_nxt      = fetch_word;                                       // RULE4
      end
      // Branch outcome
      if (dbr_exec) begin
         if (expired) begin
            count_we_nxt    = 1'b1;                                          // RULE1
            count_wdata_nxt = dec_count;                                     // RULE1
            seq_nxt         = 1'b1;                                          // RULE1
         end else if (dbr_cond_true) begin
            seq_nxt = 1'b1;                                                  // RULE2
         end else begin
            count_we_nxt    = 1'b1;
            count_wdata_nxt = dec_count;
            branch_nxt      = 1'b1;                                          // RULE3
            target_pc_nxt   = dbr_pc + PC_W'(signed'(dbr_disp));             // RULE3
         end
      end
      case (state_r)
         slm_pkg::SLM_IDLE: begin
            // Interrupts and trace keep the controller out of loop mode
            // Arm only on a looping backward branch over one eligible word
            if (dbr_exec && loops && dbr_disp == `SLM_LOOP_DISP && loop_ok(last_op_r) &&
                !trace_en && !irq_pending) begin
               state_nxt = slm_pkg::SLM_ARMED;                               // RULE6
            end
         end
         slm_pkg::SLM_ARMED: begin
            // Second fetch of the looped word confirms entry
            if (fetch_valid && fetch_word == last_op_r && loop_ok(fetch_word)) begin
               state_nxt = slm_pkg::SLM_LOOP;                                // RULE7
            end else if (fetch_valid || dbr_exec || trace_en || bus_error) begin
               state_nxt = slm_pkg::SLM_IDLE;
            end
         end
         slm_pkg::SLM_LOOP: begin
            // A bus error parks the held words until the handler returns
            // Trace has priority over the branch: a traced loop never runs
            if (bus_error) begin
               state_nxt = slm_pkg::SLM_SUSPEND;                             // RULE12
            end else if (trace_en) begin
               state_nxt = slm_pkg::SLM_IDLE;                                // RULE10
            end else if (dbr_exec && (!loops || irq_pending)) begin
               state_nxt = slm_pkg::SLM_IDLE;                                // RULE8
            end
         end
         slm_pkg::SLM_SUSPEND: begin
            // Held words survive the handler; any decrement_and_branch without rte_resume drops them
            if (rte_resume) begin
               state_nxt = slm_pkg::SLM_LOOP;                                // RULE12
            end else if (dbr_exec) begin
               state_nxt = slm_pkg::SLM_IDLE;
            end
         end
         default: begin
            state_nxt = slm_pkg::SLM_IDLE;
         end
      endcase
      loop_active_nxt   = (state_nxt == slm_pkg::SLM_LOOP);
      fetch_inhibit_nxt = loop_active_nxt;                                   // RULE5
   end

   // Plain register stage. Reset is synchronous and wins over every
   // next value, so a loop in progress is dropped on the same edge.
   // The queue is cleared too; its contents mean nothing after reset,
   // and the entry sequence refills it before it is ever held.
   // Register stage; reset clears loop mode at once
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r         <= slm_pkg::SLM_IDLE;                               // RULE11
         last_op_r       <= 16'h0000;
         loop_active_r   <= 1'b0;                                            // RULE11
         fetch_inhibit_r <= 1'b0;
         count_we_r      <= 1'b0;
         count_wdata_r   <= 16'h0000;
         branch_r        <= 1'b0;
         target_pc_r     <= '0;
         seq_r           <= 1'b0;
         irq_take_r      <= 1'b0;
         trace_req_r     <= 1'b0;
         decode_word_r   <= 16'h0000;
         queue0_r        <= 16'h0000;
         queue1_r        <= 16'h0000;
      end else begin
         state_r         <= state_nxt;
         last_op_r       <= last_op_nxt;
         loop_active_r   <= loop_active_nxt;
         fetch_inhibit_r <= fetch_inhibit_nxt;
         count_we_r      <= count_we_nxt;
         count_wdata_r   <= count_wdata_nxt;
         branch_r        <= branch_nxt;
         target_pc_r     <= target_pc_nxt;
         seq_r           <= seq_nxt;
         irq_take_r      <= irq_take_nxt;
         trace_req_r     <= trace_req_nxt;
         decode_word_r   <= decode_word_nxt;
         queue0_r        <= queue0_nxt;
         queue1_r        <= queue1_nxt;
      end
   end

endmodule
`default_nettype wire

// *** bench/slm_loop_chk.sv ***
// Checker of the loop controller: outputs tied to their causes at the inputs.
// Assumes it is bound into slm_loop_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module slm_loop_chk #(
   parameter int PC_W = 32                // Program counter width
) (
   input wire logic            clk,
   input wire logic            rst_n,
   input wire logic            trace_en,
   input wire logic            irq_pending,
   input wire logic            bus_error,
   input wire logic            rte_resume,
   input wire logic            fetch_valid,
   input wire logic            instr_exec,
   input wire logic            dbr_exec,
   input wire logic [15:0]     dbr_count,
   input wire logic            dbr_cond_true,
   input wire logic [15:0]     dbr_disp,
   input wire logic [PC_W-1:0] dbr_pc,
   input wire logic            loop_active_r,
   input wire logic            fetch_inhibit_r,
   input wire logic            count_we_r,
   input wire logic [15:0]     count_wdata_r,
   input wire logic            branch_r,
   input wire logic [PC_W-1:0] target_pc_r,
   input wire logic            seq_r,
   input wire logic            irq_take_r,
   input wire logic            trace_req_r,
   input wire logic [15:0]     decode_word_r,
   input wire logic [15:0]     queue0_r,
   input wire logic [15:0]     queue1_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Branch target with the displacement sign-extended to the program counter width
   logic [PC_W-1:0] tgt_w;
   assign tgt_w = dbr_pc + {{(PC_W-16){dbr_disp[15]}}, dbr_disp};
   AST_EXPIRE: assert property (dbr_exec && dbr_count == 16'h0000 |=>
      seq_r && !branch_r && count_we_r && count_wdata_r == 16'hffff) else $error("expired count wrong");
   AST_COND_TRUE: assert property (dbr_exec && dbr_count != 16'h0000 && dbr_cond_true |=>
      seq_r && !branch_r && !count_we_r) else $error("true condition did not fall through");
   AST_BRANCH: assert property (dbr_exec && dbr_count != 16'h0000 && !dbr_cond_true |=>
      branch_r && !seq_r && target_pc_r == $past(tgt_w)) else $error("branch outcome wrong");
   AST_FROZEN: assert property (loop_active_r |=> $stable(decode_word_r) && $stable(queue0_r)
      && $stable(queue1_r)) else $error("held loop words changed");
   AST_INHIBIT: assert property (fetch_inhibit_r == loop_active_r) else $error("fetch inhibit off");
   AST_ENTRY: assert property ($rose(loop_active_r) |-> $past(fetch_valid) || $past(rte_resume))
      else $error("loop entered without fetch");
   AST_EXIT: assert property (loop_active_r && dbr_exec && dbr_count == 16'h0000 |=> !loop_active_r)
      else $error("loop kept after count ran out");
   AST_IRQ_BRANCH: assert property (dbr_exec && irq_pending |=> irq_take_r && !loop_active_r)
      else $error("interrupt not taken after branch");
   AST_IRQ_LOOPED: assert property (loop_active_r && instr_exec && !dbr_exec |=> !irq_take_r)
      else $error("interrupt taken after looped op");
   AST_TRACE: assert property (trace_en && (instr_exec || dbr_exec) |=> trace_req_r)
      else $error("trace not raised");
   AST_RESET: assert property (disable iff (1'b0) !rst_n |=> !loop_active_r && !seq_r && !branch_r)
      else $error("reset left loop state");
   AST_BUS_ERROR: assert property (loop_active_r && bus_error |=> !loop_active_r)
      else $error("bus error did not stop loop");
endmodule
bind slm_loop_ctrl slm_loop_chk #(.PC_W(PC_W)) slm_loop_chk_inst (.*);
`default_nettype wire

// *** bench/slm_mem_model.sv ***
// Memory model that answers opcode fetches of the sequencer.
// Assumes one request pulse per word; slow adds one wait cycle.
`timescale 1ns/10ps
`default_nettype none
module slm_mem_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        req,         // Fetch request
   input  wire logic [15:0] word,        // Word stored at the fetch address
   input  wire logic        slow,        // Insert one wait cycle
   output var  logic        fetch_valid, // Word delivered, pulse
   output var  logic [15:0] fetch_word   // Delivered word
);
   logic        s1_v;                    // Delayed request for slow mode
   logic [15:0] s1_w;                    // Delayed word for slow mode
   // Outside a delivery the data toggles, so a stale word is never mistaken
   always_ff @(posedge clk) begin
      s1_v        <= req & rst_n;
      s1_w        <= word;
      fetch_valid <= rst_n & (slow ? s1_v : req);
      fetch_word  <= (slow ? s1_v : req) ? (slow ? s1_w : word) : ~fetch_word;
   end
endmodule
`default_nettype wire

// *** bench/single_instruction_loop_mode_bench.sv ***
// Testbench of the loop controller with a memory model on the fetch side.
// Assumes the checker is bound to the controller in its own file.
`timescale 1ns/10ps
`default_nettype none
module single_instruction_loop_mode_bench;
   logic clk = 0, rst_n = 0, trace_en = 0, irq_pending = 0, bus_error = 0, rte_resume = 0;
   logic instr_exec = 0, dbr_exec = 0, dbr_cond_true = 0, mem_req = 0, slow = 0, fetch_valid;
   logic [15:0] instr_word = 16'h0000, dbr_count = 16'h0000, dbr_disp = 16'h0000, mem_word = 16'h0000;
   logic [15:0] fetch_word, count_wdata_r, decode_word_r, queue0_r, queue1_r;
   logic [31:0] dbr_pc = 32'h0000_1000, target_pc_r;
   logic loop_active_r, fetch_inhibit_r, count_we_r, branch_r, seq_r, irq_take_r, trace_req_r;
   int fail_count = 0, n_tests = 0;
   // Opcode table: eligible forms and near misses that must not loop
   logic [15:0] ops [12] = '{16'h32d8, 16'h22c0, 16'h3280, 16'he1d0, 16'h4250, 16'hd050,
                             16'hd2d8, 16'hd150, 16'hc308, 16'hb348, 16'hd240, 16'he340};
   logic        oks [12] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   always #4 clk = ~clk;
   slm_loop_ctrl slm_loop_ctrl_inst (.*);
   slm_mem_model slm_mem_model_inst (.clk(clk), .rst_n(rst_n), .req(mem_req), .word(mem_word),
      .slow(slow), .fetch_valid(fetch_valid), .fetch_word(fetch_word));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Every driver enters and leaves 1 ns after a rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Each strobe task first lets one edge pass, so a strobe is never lowered and raised at once
   task automatic ins(input logic [15:0] op);
      step(1); instr_exec = 1; instr_word = op; step(1); instr_exec = 0;
   endtask
   task automatic dbr(input logic [15:0] cnt, input logic cnd, input logic [15:0] dsp);
      step(1); dbr_exec = 1; dbr_count = cnt; dbr_cond_true = cnd; dbr_disp = dsp; step(1); dbr_exec = 0;
   endtask
   task automatic fetch(input logic [15:0] w);
      step(1); mem_req = 1; mem_word = w; step(1); mem_req = 0;
   endtask
   // Looped op, looping branch, then the confirming second fetch of the op
   task automatic enter(input logic [15:0] op, input logic [15:0] dsp);
      ins(op); dbr(16'h0005, 0, dsp); fetch(op); step(3);
   endtask
   task automatic sc_outcome();
      dbr(16'h0000, 0, 16'hfffc); check({seq_r, branch_r, count_we_r}, 3'b101);
      check(count_wdata_r, 16'hffff);
      dbr(16'h0005, 1, 16'hfffc); check({seq_r, branch_r, count_we_r}, 3'b100);
      dbr(16'h0005, 0, 16'hfffc); check({seq_r, branch_r}, 2'b01);
      check(target_pc_r, 32'h0000_0ffc);
      check(count_wdata_r, 16'h0004);
      dbr(16'h8000, 0, 16'h0010); check(target_pc_r, 32'h0000_1010);
   endtask
   task automatic sc_queue();
      slow = 1; fetch(16'ha001); fetch(16'hb002); fetch(16'hc003); step(3); slow = 0;
      check({decode_word_r, queue0_r, queue1_r}, 48'ha001_b002_c003);
   endtask
   task automatic sc_table();
      for (int i = 0; i < 12; i++) begin
         enter(ops[i], 16'hfffc);
         check(loop_active_r, oks[i]);
         check(fetch_inhibit_r, oks[i]);
         dbr(16'h0000, 0, 16'hfffc); check(loop_active_r, 0);
      end
      enter(16'h32d8, 16'hfffa); check(loop_active_r, 0);
   endtask
   task automatic sc_irq_trace();
      enter(16'h32d8, 16'hfffc); irq_pending = 1; ins(16'h32d8); check(irq_take_r, 0);
      dbr(16'h0005, 0, 16'hfffc); check({irq_take_r, loop_active_r}, 2'b10);
      irq_pending = 0; trace_en = 1; ins(16'h4250); check(trace_req_r, 1);
      enter(16'h4250, 16'hfffc); check(loop_active_r, 0);
      trace_en = 0;
   endtask
   // Handler fetches during the bus error must not disturb the held loop
   task automatic sc_bus_error();
      fetch(16'h57c8); fetch(16'hfffc); enter(16'h32d8, 16'hfffc);
      bus_error = 1; step(1); bus_error = 0; check(loop_active_r, 0);
      fetch(16'h4e71); step(2);
      check({decode_word_r, queue0_r, queue1_r}, 48'h57c8_fffc_32d8);
      rte_resume = 1; step(1); rte_resume = 0; check(loop_active_r, 1);
      rst_n = 0; step(1); rst_n = 1; check({loop_active_r, fetch_inhibit_r, seq_r, branch_r}, 0);
   endtask
   initial begin
      step(5); rst_n = 1; step(1);
      check({loop_active_r, seq_r, branch_r, count_we_r, irq_take_r, trace_req_r}, 0);
      sc_outcome(); sc_queue(); sc_table(); sc_irq_trace(); sc_bus_error();
      stop_test();
   end
   // Whole run needs about 210 cycles; allow far more before giving up
   initial begin
      #100000; fail_count++; stop_test();
   end
endmodule
`default_nettype wire
